// *** rx_framer_status_latch.sv ***
// receive framer status registers: live conditions, count-nonzero flags,
// change-latched and event-latched bits, with an AXI4-Lite slave
// assumes the framer core drives all condition and event inputs on clock_i
//
// Operation
// R1 - mismatch when programmed format differs from channel
// R2 - bit 10 shows channel, one means C-bit
// R3 - live idle and unframed all-ones flags
// R4 - live multiframe-lost and severe-frame flags
// R5 - live frame-loss flag in bit 4
// R6 - bit 3 shows remote defect state
// R7 - live alarm, out-of-frame, signal-loss flags
// R8 - C-bit parity count nonzero flag
// R9 - far-end block count nonzero flag
// R10 - M23 mode zeroes all C-bit/far-end indicators
// R11 - P-bit parity count nonzero flag
// R12 - framing count nonzero, selected type
// R13 - mismatch latched on rising edge only
// R14 - change latches set on any edge
// R15 - alignment change latched on differing load
// R16 - latch C-bit and far-end error events
// R17 - latch P-bit parity error events
// R18 - latch selected framing error events
// R19 - count-rise latches on zero-to-one
// R20 - 00 out-of-frame, 01 M+F, 10 F, 11 M
// R21 - interrupt needs latch, enable, port enable
// R22 - latches sticky, set beats clear
// R23 - reserved bits read zero, ignore writes
module rx_framer_status_latch (
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_b_i,
    // axi4-lite write address and data
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [11:0] s_axi_awaddr_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    // axi4-lite write response
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    output logic [1:0]       s_axi_bresp_o,
    // axi4-lite read
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    input  wire logic [11:0] s_axi_araddr_i,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    // live conditions from the framer core
    input  wire logic        app_id_channel_i,
    input  wire logic        idle_i,
    input  wire logic        unframed_all_ones_i,
    input  wire logic        multiframe_lost_i,
    input  wire logic        severe_frame_err_i,
    input  wire logic        frame_loss_i,
    input  wire logic        remote_defect_i,
    input  wire logic        alarm_signal_i,
    input  wire logic        frame_out_i,
    input  wire logic        signal_loss_i,
    // frame alignment load from the data path counters
    input  wire logic        align_load_i,
    input  wire logic [12:0] align_pos_i,
    // error event pulses
    input  wire logic        cparity_err_i,
    input  wire logic        farend_err_i,
    input  wire logic        pparity_err_i,
    input  wire logic        f_bit_err_i,
    input  wire logic        m_bit_err_i,
    // count-nonzero levels from the error counters
    input  wire logic        cparity_count_nz_i,
    input  wire logic        farend_count_nz_i,
    input  wire logic        pparity_count_nz_i,
    input  wire logic        framing_count_nz_i,
    // global per-port interrupt enable
    input  wire logic        port_irq_enable_i,
    // outputs to the framer core and interrupt logic
    output logic             cbit_mode_o,
    output logic [1:0]       framing_err_count_select_o,
    output logic             irq_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                                awready;
        logic                                wready;
        logic                                aw_held;
        logic                                w_held;
        logic [rx_status_pkg::ADDR_W-1:0]    awaddr;
        logic [rx_status_pkg::REG_W-1:0]     wdata;
        logic [1:0]                          wstrb;
        logic                                bvalid;
        logic [1:0]                          bresp;
        logic                                arready;
        logic                                rvalid;
        logic [rx_status_pkg::DATA_W-1:0]    rdata;
        logic [1:0]                          rresp;
        logic [rx_status_pkg::REG_W-1:0]     control;
        logic [rx_status_pkg::REG_W-1:0]     mode;
        logic [rx_status_pkg::REG_W-1:0]     ie1;
        logic [rx_status_pkg::REG_W-1:0]     ie2;
        logic [rx_status_pkg::REG_W-1:0]     live1;
        logic [rx_status_pkg::REG_W-1:0]     live2;
        logic [rx_status_pkg::REG_W-1:0]     latch1;
        logic [rx_status_pkg::REG_W-1:0]     latch2;
        logic [rx_status_pkg::ALIGN_W-1:0]   align_prev;
        logic                                irq;
    } state_t;

    state_t state;
    state_t next_state;

    // ------------------------------------------------------------------
    // address decode helpers
    // ------------------------------------------------------------------
    function automatic logic [rx_status_pkg::IDX_W-1:0] word_index(
        input logic [rx_status_pkg::ADDR_W-1:0] addr
    );
        word_index = addr[rx_status_pkg::ADDR_W-1:2];
    endfunction

    function automatic logic is_mapped(input logic [rx_status_pkg::IDX_W-1:0] idx);
        unique case (idx)
            rx_status_pkg::IDX_CONTROL,
            rx_status_pkg::IDX_MODE,
            rx_status_pkg::IDX_COND,
            rx_status_pkg::IDX_ERRCNT,
            rx_status_pkg::IDX_CHG_L,
            rx_status_pkg::IDX_ERR_L,
            rx_status_pkg::IDX_IE1,
            rx_status_pkg::IDX_IE2: is_mapped = 1'b1;
            default:                is_mapped = 1'b0;
        endcase
    endfunction

    function automatic logic [rx_status_pkg::REG_W-1:0] read_reg(
        input logic [rx_status_pkg::IDX_W-1:0] idx,
        input state_t                          s
    );
        unique case (idx)
            rx_status_pkg::IDX_CONTROL: read_reg = s.control;
            rx_status_pkg::IDX_MODE:    read_reg = s.mode;
            rx_status_pkg::IDX_COND:    read_reg = s.live1;
            rx_status_pkg::IDX_ERRCNT:  read_reg = s.live2;
            rx_status_pkg::IDX_CHG_L:   read_reg = s.latch1;
            rx_status_pkg::IDX_ERR_L:   read_reg = s.latch2;
            rx_status_pkg::IDX_IE1:     read_reg = s.ie1;
            rx_status_pkg::IDX_IE2:     read_reg = s.ie2;
            default:                    read_reg = 16'h0000; // R23
        endcase
    endfunction

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic                              cbit;
        logic [1:0]                        fsel;
        logic                              fm;
        logic                              frame_evt;
        logic [rx_status_pkg::REG_W-1:0]   set1;
        logic [rx_status_pkg::REG_W-1:0]   set2;
        logic [rx_status_pkg::REG_W-1:0]   clr1;
        logic [rx_status_pkg::REG_W-1:0]   clr2;
        logic [rx_status_pkg::REG_W-1:0]   be;
        logic [rx_status_pkg::REG_W-1:0]   wbits;
        logic [rx_status_pkg::IDX_W-1:0]   widx;
        logic [rx_status_pkg::IDX_W-1:0]   ridx;
        logic                              do_write;
        cbit      = state.mode[rx_status_pkg::MODE_CBIT];
        fsel      = state.control[rx_status_pkg::SEL_LSB +: 2];
        fm        = cbit ^ app_id_channel_i; // R1
        frame_evt = 1'b0;
        set1      = 16'h0000;
        set2      = 16'h0000;
        clr1      = 16'h0000;
        clr2      = 16'h0000;
        be        = 16'h0000;
        wbits     = 16'h0000;
        widx      = 10'h000;
        ridx      = 10'h000;
        do_write  = 1'b0;
        next_state = state;

        // live condition flags, registered once from the framer core
        next_state.live1 = {4'h0,
                            fm,
                            app_id_channel_i, // R2
                            idle_i, unframed_all_ones_i, // R3
                            multiframe_lost_i, severe_frame_err_i, // R4
                            1'b0,
                            frame_loss_i, // R5
                            remote_defect_i, // R6
                            alarm_signal_i, frame_out_i, signal_loss_i}; // R7

        // count-nonzero flags; the C-bit pair reads zero outside C-bit mode
        next_state.live2 = {12'h000,
                            cparity_count_nz_i & cbit, // R8 R10
                            farend_count_nz_i & cbit, // R9 R10
                            pparity_count_nz_i, // R11
                            framing_count_nz_i}; // R12

        // framing event type picked by the count select field
        unique case (rx_status_pkg::fsel_t'(fsel))
            rx_status_pkg::FSEL_FRAME: frame_evt = frame_out_i & ~state.live1[1]; // R20
            rx_status_pkg::FSEL_MF:    frame_evt = f_bit_err_i | m_bit_err_i; // R20
            rx_status_pkg::FSEL_F:     frame_evt = f_bit_err_i; // R20
            rx_status_pkg::FSEL_M:     frame_evt = m_bit_err_i; // R20
        endcase

        // change detection against the previously registered flags
        set1 = (next_state.live1 ^ state.live1) & rx_status_pkg::ANY_EDGE_MASK; // R14
        set1[rx_status_pkg::BIT_FM] = fm & ~state.live1[rx_status_pkg::BIT_FM]; // R13
        if (align_load_i) begin
            next_state.align_prev = align_pos_i;
            set1[rx_status_pkg::BIT_COFA] = (align_pos_i != state.align_prev); // R15
        end

        set2[11] = cparity_err_i; // R16
        set2[10] = farend_err_i; // R16
        set2[9]  = pparity_err_i; // R17
        set2[8]  = frame_evt; // R18
        set2[3:0] = next_state.live2[3:0] & ~state.live2[3:0]; // R19

        // ---------------------------------------------------------------
        // axi4-lite write channel: address and data taken in either order
        // ---------------------------------------------------------------
        if (s_axi_awvalid_i && state.awready) begin
            next_state.aw_held = 1'b1;
            next_state.awaddr  = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && state.wready) begin
            next_state.w_held = 1'b1;
            next_state.wdata  = s_axi_wdata_i[rx_status_pkg::REG_W-1:0];
            next_state.wstrb  = s_axi_wstrb_i[1:0];
        end

        // the upper two byte lanes fall outside the 16-bit registers and are dropped
        do_write = state.aw_held && state.w_held && !state.bvalid;
        if (do_write) begin
            widx  = word_index(state.awaddr);
            be    = {{8{state.wstrb[1]}}, {8{state.wstrb[0]}}};
            wbits = state.wdata & be;
            next_state.aw_held = 1'b0;
            next_state.w_held  = 1'b0;
            next_state.bvalid  = 1'b1;
            next_state.bresp   = is_mapped(widx) ? rx_status_pkg::RESP_OKAY
                                                 : rx_status_pkg::RESP_SLVERR;
            unique case (widx)
                rx_status_pkg::IDX_CONTROL:
                    next_state.control = ((state.control & ~be) | wbits)
                                         & rx_status_pkg::CONTROL_MASK; // R23
                rx_status_pkg::IDX_MODE:
                    next_state.mode = ((state.mode & ~be) | wbits)
                                      & rx_status_pkg::MODE_MASK; // R23
                rx_status_pkg::IDX_IE1:
                    next_state.ie1 = ((state.ie1 & ~be) | wbits)
                                     & rx_status_pkg::CHG_L_MASK; // R23
                rx_status_pkg::IDX_IE2:
                    next_state.ie2 = ((state.ie2 & ~be) | wbits)
                                     & rx_status_pkg::ERR_L_MASK; // R23
                rx_status_pkg::IDX_CHG_L: clr1 = wbits;
                rx_status_pkg::IDX_ERR_L: clr2 = wbits;
                default: ;
            endcase
        end
        if (state.bvalid && s_axi_bready_i) begin
            next_state.bvalid = 1'b0;
        end
        next_state.awready = !next_state.aw_held && !next_state.bvalid;
        next_state.wready  = !next_state.w_held && !next_state.bvalid;

        // ---------------------------------------------------------------
        // latched bits: a set in the same cycle as a clear wins
        // ---------------------------------------------------------------
        next_state.latch1 = ((state.latch1 & ~clr1) | set1)
                            & rx_status_pkg::CHG_L_MASK; // R22 R23
        next_state.latch2 = ((state.latch2 & ~clr2) | set2)
                            & rx_status_pkg::ERR_L_MASK; // R22 R23
        if (!cbit) begin
            next_state.latch2 = next_state.latch2 & ~rx_status_pkg::CBIT_ERR_MASK; // R10
        end

        // ---------------------------------------------------------------
        // axi4-lite read channel, one read outstanding at a time
        // ---------------------------------------------------------------
        if (s_axi_arvalid_i && state.arready) begin
            ridx = word_index(s_axi_araddr_i);
            next_state.rvalid = 1'b1;
            next_state.rdata  = {16'h0000, read_reg(ridx, state)};
            next_state.rresp  = is_mapped(ridx) ? rx_status_pkg::RESP_OKAY
                                                : rx_status_pkg::RESP_SLVERR;
        end else if (state.rvalid && s_axi_rready_i) begin
            next_state.rvalid = 1'b0;
        end
        next_state.arready = !next_state.rvalid;

        // interrupt from registered latches, so it lags them by one cycle
        next_state.irq = port_irq_enable_i
                         && (|(state.latch1 & state.ie1)
                             || |(state.latch2 & state.ie2)); // R21
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            state         <= '0;
            state.control <= rx_status_pkg::CONTROL_RST;
            state.mode    <= rx_status_pkg::MODE_RST;
            state.ie1     <= rx_status_pkg::IE_RST;
            state.ie2     <= rx_status_pkg::IE_RST;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign s_axi_awready_o            = state.awready;
    assign s_axi_wready_o             = state.wready;
    assign s_axi_bvalid_o             = state.bvalid;
    assign s_axi_bresp_o              = state.bresp;
    assign s_axi_arready_o            = state.arready;
    assign s_axi_rvalid_o             = state.rvalid;
    assign s_axi_rdata_o              = state.rdata;
    assign s_axi_rresp_o              = state.rresp;
    assign cbit_mode_o                = state.mode[rx_status_pkg::MODE_CBIT];
    assign framing_err_count_select_o = state.control[rx_status_pkg::SEL_LSB +: 2];
    assign irq_o                      = state.irq;

endmodule

// *** rx_framer_status_latch_assertions.sv ***
// checker: port-level properties of the receive status register bank
// assumes it is bound into rx_framer_status_latch, one clock domain
module rx_status_checker (
    // clock, reset and bus
    input wire logic        clock_i, rst_b_i,
    input wire logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_bvalid_o,
    input wire logic        s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o,
    input wire logic [11:0] s_axi_araddr_i,
    input wire logic [31:0] s_axi_rdata_o,
    // framer side
    input wire logic        app_id_channel_i, idle_i, unframed_all_ones_i, multiframe_lost_i,
    input wire logic        severe_frame_err_i, frame_loss_i, remote_defect_i, alarm_signal_i,
    input wire logic        frame_out_i, signal_loss_i, cparity_count_nz_i, farend_count_nz_i,
    input wire logic        pparity_count_nz_i, framing_count_nz_i, port_irq_enable_i,
    input wire logic        cbit_mode_o, irq_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [10:0] live_w;
    logic [3:0]  nz_w;
    logic        rd_cond, rd_cnt;
    // read data holds inputs from the edge before the take
    assign live_w = {app_id_channel_i, idle_i, unframed_all_ones_i, multiframe_lost_i,
                     severe_frame_err_i, 1'b0, frame_loss_i, remote_defect_i, alarm_signal_i,
                     frame_out_i, signal_loss_i};
    assign nz_w = {cparity_count_nz_i & cbit_mode_o, farend_count_nz_i & cbit_mode_o,
                   pparity_count_nz_i, framing_count_nz_i};
    assign rd_cond = s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i[11:2] == 10'h124;
    assign rd_cnt = s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i[11:2] == 10'h126;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    AST_COND_LIVE: assert property (rd_cond |=> s_axi_rdata_o[10:0] == $past(live_w, 2))
        else $error("live condition bits differ from inputs");
    AST_MISMATCH: assert property (rd_cond |=>
        s_axi_rdata_o[11] == ($past(cbit_mode_o, 2) ^ $past(app_id_channel_i, 2)))
        else $error("format mismatch bit wrong");
    AST_CNT_CBIT: assert property (rd_cnt |=> s_axi_rdata_o[3:2] == $past(nz_w[3:2], 2))
        else $error("C-bit count flags wrong");
    AST_CNT_PF: assert property (rd_cnt |=> s_axi_rdata_o[1:0] == $past(nz_w[1:0], 2))
        else $error("parity or framing count flag wrong");
    AST_RSVD: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000)
        else $error("upper read data not zero");
    AST_IRQ_GATE: assert property (!port_irq_enable_i |=> !irq_o)
        else $error("interrupt without port enable");
    AST_READ_LAT: assert property (s_axi_arvalid_i && s_axi_arready_o
        |=> s_axi_rvalid_o && !s_axi_arready_o)
        else $error("read answer late");
    AST_WRITE_RESP: assert property (s_axi_awvalid_i && s_axi_awready_o |-> ##[1:4] s_axi_bvalid_o)
        else $error("write response missing");
endmodule

bind rx_framer_status_latch rx_status_checker u_rx_status_checker (.*);

// *** rx_status_pkg.sv ***
// constants for the receive framer status and latched-status register bank
// assumes a 32-bit AXI4-Lite master and a framer core on the same clock
package rx_status_pkg;

    // ------------------------------------------------------------------
    // bus widths and responses
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W  = 12;
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned REG_W   = 16;
    localparam int unsigned IDX_W   = 10;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // register indices, byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_CONTROL = 10'h120;
    localparam logic [IDX_W-1:0] IDX_MODE    = 10'h122;
    localparam logic [IDX_W-1:0] IDX_COND    = 10'h124;
    localparam logic [IDX_W-1:0] IDX_ERRCNT  = 10'h126;
    localparam logic [IDX_W-1:0] IDX_CHG_L   = 10'h128;
    localparam logic [IDX_W-1:0] IDX_ERR_L   = 10'h12A;
    localparam logic [IDX_W-1:0] IDX_IE1     = 10'h12C;
    localparam logic [IDX_W-1:0] IDX_IE2     = 10'h12E;

    // ------------------------------------------------------------------
    // implemented-bit masks and reset values
    // ------------------------------------------------------------------
    localparam logic [REG_W-1:0] CONTROL_MASK  = 16'h7FFF;
    localparam logic [REG_W-1:0] MODE_MASK     = 16'h0001;
    localparam logic [REG_W-1:0] CHG_L_MASK    = 16'h0FFF;
    localparam logic [REG_W-1:0] ERR_L_MASK    = 16'h0F0F;
    localparam logic [REG_W-1:0] ANY_EDGE_MASK = 16'h07DF;
    localparam logic [REG_W-1:0] CBIT_ERR_MASK = 16'h0C0C;
    localparam logic [REG_W-1:0] CONTROL_RST   = 16'h0000;
    localparam logic [REG_W-1:0] MODE_RST      = 16'h0001;
    localparam logic [REG_W-1:0] IE_RST        = 16'h0000;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int unsigned SEL_LSB    = 8;
    localparam int unsigned MODE_CBIT  = 0;
    localparam int unsigned BIT_FM     = 11;
    localparam int unsigned BIT_COFA   = 5;
    localparam int unsigned ALIGN_W    = 13;

    typedef enum logic [1:0] {
        FSEL_FRAME = 2'h0,
        FSEL_MF    = 2'h1,
        FSEL_F     = 2'h2,
        FSEL_M     = 2'h3
    } fsel_t;

endpackage

// *** testbench.sv ***
// testbench: random framer conditions and bus traffic against a model
// assumes the design and its checker are compiled ahead of this file
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clock_i, rst_b_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
    logic        s_axi_arvalid_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o;
    logic        s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, cbit_mode_o, irq_o;
    logic [11:0] s_axi_awaddr_i, s_axi_araddr_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o, seed;
    logic [3:0]  s_axi_wstrb_i;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, framing_err_count_select_o;
    logic        app_id_channel_i, idle_i, unframed_all_ones_i, multiframe_lost_i;
    logic        severe_frame_err_i, frame_loss_i, remote_defect_i, alarm_signal_i;
    logic        frame_out_i, signal_loss_i, cparity_count_nz_i, farend_count_nz_i;
    logic        pparity_count_nz_i, framing_count_nz_i, port_irq_enable_i, align_load_i;
    logic        cparity_err_i, farend_err_i, pparity_err_i, f_bit_err_i, m_bit_err_i;
    logic [12:0] align_pos_i, last_align;
    logic [13:0] levels;
    logic [5:0]  pulses;
    logic [15:0] live_cond, live_cnt, chg_lat, err_lat, ctrl_reg, ie1_reg, ie2_reg, d, nv;
    logic        mode_bit, fev, exp_irq;
    int          mismatches, checks;

    assign {app_id_channel_i, idle_i, unframed_all_ones_i, multiframe_lost_i,
            severe_frame_err_i, frame_loss_i, remote_defect_i, alarm_signal_i, frame_out_i,
            signal_loss_i, cparity_count_nz_i, farend_count_nz_i, pparity_count_nz_i,
            framing_count_nz_i} = levels;
    assign {align_load_i, cparity_err_i, farend_err_i, pparity_err_i, f_bit_err_i,
            m_bit_err_i} = pulses;

    rx_framer_status_latch u_rx_framer_status_latch (.*);

    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // bus master
    // ------------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
        @(posedge clock_i);
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= v;
        s_axi_bready_i <= 1'b1;
        do begin
            @(posedge clock_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
        end while (!s_axi_bvalid_o);
        s_axi_bready_i <= 1'b0;
        cmp(32'(s_axi_bresp_o), 32'(er));
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clock_i);
        s_axi_arvalid_i <= 1'b1;
        s_axi_araddr_i <= a;
        s_axi_rready_i <= 1'b1;
        do begin
            @(posedge clock_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
        end while (!s_axi_rvalid_o);
        s_axi_rready_i <= 1'b0;
        cmp(s_axi_rdata_o, e);
        cmp(32'(s_axi_rresp_o), 32'(er));
    endtask

    // ------------------------------------------------------------------
    // reference model, updated on the same edges as the design
    // ------------------------------------------------------------------
    always @(posedge clock_i) begin
        if (!rst_b_i) begin
            {live_cond, live_cnt, chg_lat, err_lat, ctrl_reg, ie1_reg, ie2_reg} = '0;
            last_align = 13'h0000;
            mode_bit = 1'b1;
        end else begin
            case (ctrl_reg[9:8])
                2'h0: fev = levels[5] & ~live_cond[1];
                2'h1: fev = pulses[1] | pulses[0];
                2'h2: fev = pulses[1];
                default: fev = pulses[0];
            endcase
            nv = {4'h0, mode_bit ^ levels[13], levels[13:9], 1'b0, levels[8:4]};
            chg_lat = chg_lat | ((nv ^ live_cond) & 16'h07DF);
            chg_lat[11] = chg_lat[11] | (nv[11] & ~live_cond[11]);
            if (pulses[5] && align_pos_i != last_align) chg_lat[5] = 1'b1;
            if (pulses[5]) last_align = align_pos_i;
            live_cond = nv;
            nv = {12'h000, levels[3:2] & {2{mode_bit}}, levels[1:0]};
            err_lat = err_lat | {4'h0, pulses[4:2], fev, 4'h0, nv[3:0] & ~live_cnt[3:0]};
            if (!mode_bit) err_lat = err_lat & 16'hF3F3;
            live_cnt = nv;
        end
    end

    initial begin
        repeat (20000) @(posedge clock_i);
        mismatches++;
        end_sim();
    end

    initial begin
        seed = 32'h4C;
        mismatches = 0;
        checks = 0;
        {rst_b_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i} = '0;
        {s_axi_rready_i, port_irq_enable_i, s_axi_awaddr_i, s_axi_araddr_i} = '0;
        {s_axi_wdata_i, align_pos_i, levels, pulses} = '0;
        s_axi_wstrb_i = 4'hF;
        repeat (12) @(posedge clock_i);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rd_chk(12'h480, 32'h0, 2'h0);
        rd_chk(12'h4C0, 32'h0, 2'h2);
        wr(12'h490, 32'hFFFF_FFFF, 2'h0);
        wr(12'h488, 32'hFFFF_FFFE, 2'h0);
        mode_bit = 1'b0;
        rd_chk(12'h488, 32'h0, 2'h0);
        for (int i = 0; i < 48; i++) begin
            repeat (8) begin
                @(posedge clock_i);
                seed = xs(seed);
                levels <= levels ^ (seed[13:0] & seed[27:14]);
                pulses <= seed[31:26] & seed[5:0];
                align_pos_i <= {10'h000, seed[8:6]};
            end
            @(posedge clock_i);
            pulses <= 6'h00;
            repeat (3) @(posedge clock_i);
            exp_irq = port_irq_enable_i && ((chg_lat & ie1_reg) | (err_lat & ie2_reg)) != 0;
            cmp(32'(irq_o), 32'(exp_irq));
            rd_chk(12'h490, 32'(live_cond), 2'h0);
            rd_chk(12'h498, 32'(live_cnt), 2'h0);
            rd_chk(12'h4A0, 32'(chg_lat), 2'h0);
            rd_chk(12'h4A8, 32'(err_lat), 2'h0);
            seed = xs(seed);
            wr(12'h4A0, seed, 2'h0);
            chg_lat = chg_lat & ~seed[15:0];
            wr(12'h4A8, 32'(seed[31:16]), 2'h0);
            err_lat = err_lat & ~seed[31:16];
            d = {seed[15:10], i[1:0], seed[7:0]};
            wr(12'h480, {16'hFFFF, d}, 2'h0);
            ctrl_reg = d & 16'h7FFF;
            rd_chk(12'h480, 32'(ctrl_reg), 2'h0);
            cmp(32'(framing_err_count_select_o), 32'(i[1:0]));
            wr(12'h488, 32'(seed[16]), 2'h0);
            mode_bit = seed[16];
            cmp(32'(cbit_mode_o), 32'(mode_bit));
            wr(12'h4B0, seed, 2'h0);
            ie1_reg = seed[15:0] & 16'h0FFF;
            wr(12'h4B8, 32'(seed[31:16]), 2'h0);
            ie2_reg = seed[31:16] & 16'h0F0F;
            port_irq_enable_i <= seed[20];
        end
        end_sim();
    end
endmodule
